/* File: core/mrs_pkg.sv */
// package: register map, field layout and constants of the step sequencer
package mrs_pkg;
  localparam int unsigned NUM_REFS      = 16;
  localparam int unsigned REF_W         = 11;
  localparam int unsigned DUR_W         = 16;
  localparam int unsigned REF_MAX_TENTH = 1000;
  localparam logic [10:0] REF_RESET     = 11'h000;
  localparam logic [15:0] DUR_RESET     = 16'h0000;
  localparam logic [1:0]  RAMP_RESET    = 2'h0;
  localparam logic [1:0]  END_RESET     = 2'h0;
  localparam logic [2:0]  SRC_RESET     = 3'h0;

  // byte offsets on the register bus
  localparam logic [11:0] ADDR_REF_BASE  = 12'h000; // 16 words
  localparam logic [11:0] ADDR_STEP_BASE = 12'h040; // 16 words
  localparam logic [11:0] ADDR_CTRL      = 12'h080;
  localparam logic [11:0] ADDR_SCALE     = 12'h084;
  localparam logic [11:0] ADDR_STATUS    = 12'h088;
  localparam logic [11:0] ADDR_OUT       = 12'h08c;

  // ctrl register fields
  localparam int unsigned CTRL_END_LSB   = 0;  // 2 bits end mode
  localparam int unsigned CTRL_PFRET_BIT = 2;  // keep on power loss
  localparam int unsigned CTRL_STRET_BIT = 3;  // keep on stop
  localparam int unsigned CTRL_UNIT_BIT  = 4;  // 0 s, 1 h
  localparam int unsigned CTRL_SRC_LSB   = 5;  // 3 bits ref zero source
  localparam int unsigned CTRL_SEQ_BIT   = 8;  // sequencer selects ref
  localparam int unsigned CTRL_DEST_LSB  = 9;  // 2 bits destination
  // step register fields
  localparam int unsigned STEP_RAMP_LSB  = 16;

  // time base: durations are tenths of a unit
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned TENTH_S_MS     = 100;
  localparam int unsigned TENTH_S_CYC    = CLK_HZ / 1000 * TENTH_S_MS;
  localparam int unsigned HOUR_PER_S     = 3600;

  typedef enum logic [1:0] {
    MRS_END_STOP, MRS_END_HOLD, MRS_END_REPEAT, MRS_END_RSVD
  } mrs_end_t;

  typedef enum logic [1:0] {
    MRS_DEST_FREQ, MRS_DEST_VOLT, MRS_DEST_PID, MRS_DEST_RSVD
  } mrs_dest_t;

  typedef enum logic [2:0] {
    MRS_SRC_STORED, MRS_SRC_AIN1, MRS_SRC_AIN2, MRS_SRC_AIN3,
    MRS_SRC_PULSE, MRS_SRC_PID, MRS_SRC_PRESET
  } mrs_src_t;
endpackage : mrs_pkg

/* File: core/mrs_scaler.sv */
// scales a signed tenth-percent value against a full-scale base
module mrs_scaler #(
  parameter int unsigned BASE_W = 16
) (
  // clock and reset
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst_n,
  // operands
  input  wire logic signed [10:0]   i_pct,
  input  wire logic [BASE_W-1:0]    i_base,
  input  wire logic                 i_bypass,
  // result
  output logic signed [BASE_W:0]    o_value
);
  logic signed [BASE_W+12:0] prod;
  logic signed [BASE_W+12:0] quot;

  // pid setpoint is left in tenth-percent units
  always_comb begin
    prod = i_pct * $signed({1'b0, i_base});
    quot = prod / $signed((BASE_W+13)'(mrs_pkg::REF_MAX_TENTH));
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_value <= '0;
    end else if (i_bypass) begin
      o_value <= (BASE_W+1)'(i_pct);
    end else begin
      o_value <= quot[BASE_W:0];
    end
  end
endmodule : mrs_scaler

/* File: core/mrs_seq.sv */
// multi-reference store with timed step sequencer and apb access
module mrs_seq #(
  parameter int unsigned TENTH_CYC = mrs_pkg::TENTH_S_CYC,
  parameter int unsigned HOUR_MUL  = mrs_pkg::HOUR_PER_S
) (
  // clock and reset
  input  wire logic               i_mclk,
  input  wire logic               i_rst_n,
  // apb slave
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [11:0]        i_paddr,
  input  wire logic [31:0]        i_pwdata,
  output logic [31:0]             o_prdata,
  output logic                    o_pready,
  output logic                    o_pslverr,
  // run control and terminals
  input  wire logic               i_run,
  input  wire logic               i_stop,
  input  wire logic               i_power_up,
  input  wire logic [3:0]         i_digital_input_terminal,
  // reference zero sources, tenth percent
  input  wire logic signed [10:0] i_analog_input_one,
  input  wire logic signed [10:0] i_analog_input_two,
  input  wire logic signed [10:0] i_analog_input_three,
  input  wire logic signed [10:0] i_pulse_ref,
  input  wire logic signed [10:0] i_pid_ref,
  input  wire logic signed [10:0] i_preset_frequency_setting,
  // scaling bases
  input  wire logic [15:0]        i_max_freq,
  input  wire logic [15:0]        i_rated_volt,
  // drive core side
  output logic signed [16:0]      o_setpoint,
  output logic [1:0]              o_dest,
  output logic                    o_reverse,
  output logic [1:0]              o_ramp_sel,
  output logic                    o_running,
  output logic [3:0]              o_step
);
  logic signed [10:0] ref_r   [16];
  logic [15:0]        dur_r   [16];
  logic [1:0]         ramp_r  [16];
  logic [1:0]         end_r;
  logic               pfret_r;
  logic               stret_r;
  logic               unit_r;
  logic [2:0]         src_r;
  logic               seq_r;
  logic [1:0]         dest_r;

  logic               run_r;
  logic               run_d_r;
  logic               done_r;
  logic [3:0]         step_r;
  logic [15:0]        tenth_r;
  logic [31:0]        tick_r;
  logic signed [10:0] hold_r;
  logic               pend_r;
  logic [31:0]        tick_lim;
  logic               tick_end;
  logic               step_end;
  logic signed [10:0] ref0;
  logic signed [10:0] sel_pct;
  logic [15:0]        base;
  logic signed [16:0] scaled;

  wire wr_en = i_psel & i_penable & i_pwrite;
  wire rd_en = i_psel & ~i_pwrite;
  wire run_go = i_run & ~run_d_r;

  // clamp to the legal tenth-percent range
  function automatic logic signed [10:0] clamp_ref(input logic [31:0] d);
    logic signed [31:0] v;
    v = $signed(d);
    if (v > $signed(32'(mrs_pkg::REF_MAX_TENTH))) begin
      clamp_ref = 11'sd1000;
    end else if (v < -$signed(32'(mrs_pkg::REF_MAX_TENTH))) begin
      clamp_ref = -11'sd1000;
    end else begin
      clamp_ref = v[10:0];
    end
  endfunction : clamp_ref

  // decode an address inside a 16-word array
  function automatic logic in_bank(input logic [11:0] a,
                                   input logic [11:0] b);
    in_bank = (a >= b) && (a < b + 12'h040) && (a[1:0] == 2'h0);
  endfunction : in_bank

  wire [3:0] widx = i_paddr[5:2];

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 16; i++) begin
        ref_r[i]  <= mrs_pkg::REF_RESET;
        dur_r[i]  <= mrs_pkg::DUR_RESET;
        ramp_r[i] <= mrs_pkg::RAMP_RESET;
      end
    end else if (wr_en && in_bank(i_paddr, mrs_pkg::ADDR_REF_BASE)) begin
      ref_r[widx] <= clamp_ref(i_pwdata);
    end else if (wr_en && in_bank(i_paddr, mrs_pkg::ADDR_STEP_BASE)) begin
      dur_r[widx]  <= i_pwdata[15:0];
      ramp_r[widx] <= i_pwdata[mrs_pkg::STEP_RAMP_LSB +: 2];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      end_r   <= mrs_pkg::END_RESET;
      pfret_r <= 1'b0;
      stret_r <= 1'b0;
      unit_r  <= 1'b0;
      src_r   <= mrs_pkg::SRC_RESET;
      seq_r   <= 1'b0;
      dest_r  <= 2'h0;
    end else if (wr_en && i_paddr == mrs_pkg::ADDR_CTRL) begin
      end_r   <= i_pwdata[mrs_pkg::CTRL_END_LSB +: 2];
      pfret_r <= i_pwdata[mrs_pkg::CTRL_PFRET_BIT];
      stret_r <= i_pwdata[mrs_pkg::CTRL_STRET_BIT];
      unit_r  <= i_pwdata[mrs_pkg::CTRL_UNIT_BIT];
      src_r   <= i_pwdata[mrs_pkg::CTRL_SRC_LSB +: 3];
      seq_r   <= i_pwdata[mrs_pkg::CTRL_SEQ_BIT];
      dest_r  <= i_pwdata[mrs_pkg::CTRL_DEST_LSB +: 2];
    end
  end

  // apb answers in the access cycle, zero wait states
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_prdata  <= '0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= 1'b0;
      o_prdata  <= '0;
      if (rd_en && !i_penable) begin
        if (in_bank(i_paddr, mrs_pkg::ADDR_REF_BASE)) begin
          o_prdata <= 32'($signed(ref_r[widx]));
        end else if (in_bank(i_paddr, mrs_pkg::ADDR_STEP_BASE)) begin
          o_prdata <= {14'h0, ramp_r[widx], dur_r[widx]};
        end else if (i_paddr == mrs_pkg::ADDR_CTRL) begin
          o_prdata <= {21'h0, dest_r, seq_r, src_r, unit_r, stret_r,
                       pfret_r, end_r};
        end else if (i_paddr == mrs_pkg::ADDR_STATUS) begin
          o_prdata <= {10'h0, tenth_r, done_r, run_r, step_r};
        end else if (i_paddr == mrs_pkg::ADDR_OUT) begin
          o_prdata <= 32'(o_setpoint);
        end else begin
          o_pslverr <= 1'b1;
        end
      end
    end
  end

  // hours stretch each tenth by the seconds-per-hour factor
  always_comb begin
    tick_lim = unit_r ? 32'(TENTH_CYC * HOUR_MUL) - 32'd1
                      : 32'(TENTH_CYC) - 32'd1;
    tick_end = (tick_r == tick_lim);
    step_end = (tenth_r >= dur_r[step_r]) ||
               (tick_end && (tenth_r + 16'h1 >= dur_r[step_r]));
  end

  // start on a rising run edge so a held run cannot restart
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      run_d_r <= 1'b0;
    end else begin
      run_d_r <= i_run;
    end
  end

  // pending power-loss resume, latched on i_power_up, cleared by run
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pend_r <= 1'b0;
    end else if (i_power_up) begin
      pend_r <= pfret_r;
    end else if (i_run) begin
      pend_r <= 1'b0;
    end
  end

  // position is held in flops across i_power_up only when pfret_r is set; otherwise it returns to step 0
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      run_r   <= 1'b0;
      done_r  <= 1'b0;
      step_r  <= 4'h0;
      tenth_r <= 16'h0;
      tick_r  <= 32'h0;
      hold_r  <= 11'sh000;
    end else if (i_stop) begin
      run_r <= 1'b0;
      if (!stret_r) begin
        step_r  <= 4'h0;
        tenth_r <= 16'h0;
        tick_r  <= 32'h0;
      end
    end else if (i_power_up && !pfret_r) begin
      run_r   <= 1'b0;
      step_r  <= 4'h0;
      tenth_r <= 16'h0;
      tick_r  <= 32'h0;
    end else if (run_go && !run_r) begin
      run_r  <= 1'b1;
      done_r <= 1'b0;
      if (done_r || !(stret_r || pend_r)) begin
        step_r  <= 4'h0;
        tenth_r <= 16'h0;
        tick_r  <= 32'h0;
      end
    end else if (run_r && seq_r && !done_r) begin
      if (step_end) begin
        tick_r  <= 32'h0;
        tenth_r <= 16'h0;
        if (step_r == 4'hf) begin
          case (mrs_pkg::mrs_end_t'(end_r))
            mrs_pkg::MRS_END_STOP: begin
              run_r  <= 1'b0;
              done_r <= 1'b1;
            end
            mrs_pkg::MRS_END_HOLD: begin
              done_r <= 1'b1;
              hold_r <= ref_r[4'hf];
            end
            mrs_pkg::MRS_END_REPEAT: begin
              step_r <= 4'h0;
            end
            default: begin
              run_r  <= 1'b0;
              done_r <= 1'b1;
            end
          endcase
        end else begin
          step_r <= step_r + 4'h1;
        end
      end else if (tick_end) begin
        tick_r  <= 32'h0;
        tenth_r <= tenth_r + 16'h1;
      end else begin
        tick_r <= tick_r + 32'h1;
      end
    end
  end

  always_comb begin
    case (mrs_pkg::mrs_src_t'(src_r))
      mrs_pkg::MRS_SRC_STORED: ref0 = ref_r[0];
      mrs_pkg::MRS_SRC_AIN1:   ref0 = i_analog_input_one;
      mrs_pkg::MRS_SRC_AIN2:   ref0 = i_analog_input_two;
      mrs_pkg::MRS_SRC_AIN3:   ref0 = i_analog_input_three;
      mrs_pkg::MRS_SRC_PULSE:  ref0 = i_pulse_ref;
      mrs_pkg::MRS_SRC_PID:    ref0 = i_pid_ref;
      mrs_pkg::MRS_SRC_PRESET: ref0 = i_preset_frequency_setting;
      default:                 ref0 = ref_r[0];
    endcase
  end

  // sequencer may not feed pid duty; a pid destination falls back to frequency
  wire [1:0] dest_eff = (seq_r && dest_r == 2'(mrs_pkg::MRS_DEST_PID))
                        ? 2'(mrs_pkg::MRS_DEST_FREQ) : dest_r;
  wire [3:0] idx = seq_r ? step_r : i_digital_input_terminal;

  always_comb begin
    if (seq_r && run_r && done_r &&
        end_r == 2'(mrs_pkg::MRS_END_HOLD)) begin
      sel_pct = hold_r;
    end else if (seq_r && !run_r) begin
      sel_pct = 11'sh000;
    end else if (idx == 4'h0) begin
      sel_pct = ref0;
    end else begin
      sel_pct = ref_r[idx];
    end
    base = (dest_eff == 2'(mrs_pkg::MRS_DEST_VOLT)) ? i_rated_volt
                                                    : i_max_freq;
  end

  mrs_scaler #(
    .BASE_W (16)
  ) u_scale (
    .i_mclk   (i_mclk),
    .i_rst_n  (i_rst_n),
    .i_pct    (sel_pct),
    .i_base   (base),
    .i_bypass (dest_eff == 2'(mrs_pkg::MRS_DEST_PID)),
    .o_value  (scaled)
  );

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_setpoint <= '0;
      o_dest     <= 2'h0;
      o_reverse  <= 1'b0;
      o_ramp_sel <= 2'h0;
      o_running  <= 1'b0;
      o_step     <= 4'h0;
    end else begin
      o_setpoint <= scaled;
      o_dest     <= dest_eff;
      o_reverse  <= (dest_eff == 2'(mrs_pkg::MRS_DEST_FREQ)) &&
                    sel_pct[10];
      o_ramp_sel <= ramp_r[step_r];
      o_running  <= run_r;
      o_step     <= step_r;
    end
  end
endmodule : mrs_seq

/* File: bench/mrs_seq_properties.sv */
// checker: apb handshake and sequencer run properties
module mrs_seq_chk (
  // watched ports
  input wire logic        i_mclk,
  input wire logic        i_rst_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic        i_run,
  input wire logic        i_stop,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic [1:0]  o_dest,
  input wire logic        o_reverse,
  input wire logic        o_running,
  input wire logic [3:0]  o_step
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_idle;
    !o_running && !$past(i_run);
  endsequence
  property p_ans;
    s_setup |=> o_pready;
  endproperty
  property p_one;
    !(i_psel && !i_penable) |=> !o_pready;
  endproperty
  property p_unmap;
    s_setup ##0 (!i_pwrite && i_paddr == 12'h084)
      |=> o_pslverr && o_prdata == 32'h0;
  endproperty
  property p_stop;
    i_stop |=> ##1 !o_running;
  endproperty
  property p_idle;
    s_idle |=> !o_running;
  endproperty
  property p_start;
    !o_running && $rose(i_run) && !i_stop |=> ##1 o_running;
  endproperty
  property p_asc;
    o_running && $past(o_running) && $changed(o_step)
      |-> o_step == $past(o_step) + 4'h1;
  endproperty
  property p_rev;
    o_reverse |-> o_dest == 2'h0;
  endproperty
  a_ans: assert property (p_ans) else $error("pready missing");
  a_one: assert property (p_one) else $error("stray pready");
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  a_stop: assert property (p_stop) else $error("stop ignored");
  a_idle: assert property (p_idle) else $error("self restart");
  a_start: assert property (p_start) else $error("run ignored");
  a_asc: assert property (p_asc) else $error("step order");
  a_rev: assert property (p_rev) else $error("reverse duty");
endmodule : mrs_seq_chk

/* File: bench/mrs_core_model.sv */
// drive core model: applies setpoint, direction and ramp set
module mrs_core_model (
  // clock and reset
  input  wire logic               i_mclk,
  input  wire logic               i_rst_n,
  // from the sequencer
  input  wire logic signed [16:0] i_setpoint,
  input  wire logic               i_reverse,
  input  wire logic [1:0]         i_ramp_sel,
  // applied command
  output logic signed [16:0]      o_cmd,
  output logic                    o_dir,
  output logic [1:0]              o_ramp
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_cmd  <= '0;
      o_dir  <= 1'b0;
      o_ramp <= 2'h0;
    end else begin
      o_cmd  <= i_setpoint;
      o_dir  <= i_reverse;
      o_ramp <= i_ramp_sel;
    end
  end
endmodule : mrs_core_model

/* File: bench/mrs_seq_tb.sv */
// testbench for the multi-reference step sequencer
module mrs_seq_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic               mclk, rst_n, psel, penable, pwrite;
  logic               run, stop, pwr, pready, pslverr, err;
  logic               rev, running, dir;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [3:0]         dit, step;
  logic signed [10:0] ain [6];
  logic [15:0]        fmax, vrat;
  logic signed [16:0] sp, cmd;
  logic [1:0]         dest, ramp, mramp;
  int                 bad_count, n_checks, kilo, cs, ch;

  mrs_seq #(.TENTH_CYC(4), .HOUR_MUL(2)) DUT (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_run(run), .i_stop(stop),
    .i_power_up(pwr), .i_digital_input_terminal(dit),
    .i_analog_input_one(ain[0]), .i_analog_input_two(ain[1]),
    .i_analog_input_three(ain[2]), .i_pulse_ref(ain[3]),
    .i_pid_ref(ain[4]), .i_preset_frequency_setting(ain[5]),
    .i_max_freq(fmax), .i_rated_volt(vrat), .o_setpoint(sp),
    .o_dest(dest), .o_reverse(rev), .o_ramp_sel(ramp),
    .o_running(running), .o_step(step));
  mrs_core_model u_core (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_setpoint(sp),
    .i_reverse(rev), .i_ramp_sel(ramp), .o_cmd(cmd),
    .o_dir(dir), .o_ramp(mramp));

  initial begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end

  task conclude;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // master holds the request until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) bad_count++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task kick(input int w);
    @(posedge mclk);
    if (w == 0) run <= 1; else if (w == 1) stop <= 1; else pwr <= 1;
    @(posedge mclk);
    run <= 0; stop <= 0; pwr <= 0;
  endtask : kick

  task wt(input logic [3:0] s);
    int k;
    k = 0;
    while (step !== s && k < 600) begin
      @(negedge mclk);
      k++;
    end
    chk(step, s);
  endtask : wt

  task t_regs;
    apb(0, 12'h014, 0); chk(rd, 0);
    apb(0, 12'h04c, 0); chk(rd, 0);
    apb(0, 12'h084, 0); chk(err, 1'b1); chk(rd, 0);
    apb(1, 12'h008, 32'h3fc); apb(0, 12'h008, 0);
    chk(rd[10:0], 11'h3e8);
    apb(1, 12'h048, 32'h3_0005); apb(0, 12'h048, 0);
    chk(rd[17:0], 18'h3_0005);
  endtask : t_regs

  task t_scale;
    int p, e;
    p = $signed(32'hffff_ff06);
    @(posedge mclk);
    fmax <= 16'h07d0; vrat <= 16'h0190; dit <= 4'h3;
    apb(1, 12'h00c, 32'(p));
    for (int d = 0; d < 3; d++) begin
      apb(1, 12'h080, 32'(d) << 9);
      cyc(4);
      e = (d == 2) ? p : p * int'(d == 0 ? fmax : vrat) / kilo;
      chk(32'(sp), e);
      chk(32'(dest), 32'(d));
    end
    apb(1, 12'h010, 32'h1f4);
    @(posedge mclk);
    dit <= 4'h4;
    cyc(4);
    chk(32'(sp), 32'h1f4);
  endtask : t_scale

  task t_src;
    @(posedge mclk);
    dit <= 4'h0;
    apb(1, 12'h000, 32'h4d);
    for (int c = 0; c < 7; c++) begin
      apb(1, 12'h080, 32'h400 | (32'(c) << 5));
      cyc(4);
      chk(32'(sp), c == 0 ? 32'h4d : 32'(ain[c-1]));
    end
  endtask : t_src

  task t_end(input logic [1:0] m);
    apb(1, 12'h080, 32'h100 | 32'(m) | (m[1] ? 32'h400 : 32'h0));
    kick(0);
    cyc(2);
    chk(ramp, 2'h2);
    wt(4'hf);
    cyc(20);
    chk(running, m != 2'h0);
    chk(dest, 2'h0);
    if (m == 2'h1) begin
      chk(step, 4'hf);
      chk(dir, 1'b1);
      chk(32'(sp), $signed(32'hffff_fed4) * int'(fmax) / kilo);
    end
    kick(1);
    cyc(2);
    chk(running, 1'b0);
  endtask : t_end

  task t_meas(input logic u, output int c);
    apb(1, 12'h080, 32'h100 | (32'(u) << 4));
    kick(0);
    c = 0;
    for (int k = 0; k < 200; k++) begin
      @(negedge mclk);
      if (running && step == 4'h0) c++;
      else if (c > 0) break;
    end
    kick(1);
  endtask : t_meas

  task t_ret(input logic [31:0] c, input logic p, input logic [3:0] e);
    apb(1, 12'h080, 32'h100 | c);
    kick(0);
    cyc(2);
    wt(4'h1);
    kick(1);
    cyc(2);
    if (p) kick(2);
    kick(0);
    cyc(2);
    chk(step, e);
    kick(1);
  endtask : t_ret

  initial begin
    {rst_n, psel, penable, pwrite, run, stop, pwr} = '0;
    paddr = '0; pwdata = '0; dit = '0; fmax = '0; vrat = '0;
    for (int k = 0; k < 6; k++) ain[k] = 11'(11 * (k + 1));
    kilo = 32'h3e8;
    repeat (8) @(posedge mclk);
    rst_n <= 1;
    t_regs;
    t_scale;
    t_src;
    apb(1, 12'h000, 32'h64);
    apb(1, 12'h03c, 32'hffff_fed4);
    apb(1, 12'h040, 32'h2_0001);
    for (int m = 0; m < 3; m++) t_end(2'(m));
    t_meas(1'b0, cs);
    t_meas(1'b1, ch);
    chk(ch - cs, 32'h4);
    apb(1, 12'h044, 32'h64);
    t_ret(32'h8, 1'b0, 4'h1);
    t_ret(32'h0, 1'b0, 4'h0);
    t_ret(32'hc, 1'b1, 4'h1);
    t_ret(32'h8, 1'b1, 4'h0);
    conclude;
  end

  // run needs a few hundred cycles; far beyond that is a hang
  initial begin
    #2000000;
    bad_count++;
    conclude;
  end
endmodule : mrs_seq_tb

bind mrs_seq mrs_seq_chk u_chk (.*);
